// File: verilog/serial_port_params.svh
// Register offsets, field positions, reset values and timing counts
`ifndef SERIAL_PORT_PARAMS_SVH
`define SERIAL_PORT_PARAMS_SVH
// ============================================================
// Register byte offsets
`define OFF_CONTROL_THREE 12'h000
`define OFF_RX_BUFFER     12'h004
`define OFF_STATUS        12'h008
`define OFF_MODE          12'h00c
`define OFF_IRQ_STATUS    12'h010
`define OFF_IRQ_MASK      12'h014
// ============================================================
// Control three field positions
`define BIT_OVERWRITE     4
`define BIT_HOLD_SELECT   3
`define CONTROL_THREE_RST 8'h00
// ============================================================
// Status and interrupt bits
`define BIT_FULL          0
`define BIT_OVERFLOW      1
`define IRQ_RX            0
`define IRQ_OVF           1
// ============================================================
// Hold times
`define CLK_PERIOD_NS     50
`define HOLD_LONG_NS      300
`define HOLD_SHORT_NS     100
`define HOLD_LONG_CYC     ((`HOLD_LONG_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define HOLD_SHORT_CYC    ((`HOLD_SHORT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// File: verilog/serial_port_pkg.sv
// Types shared by the serial port receive block
package serial_port_pkg;
  typedef enum logic [1:0] {MODE_SPI_SLAVE, MODE_I2C_MASTER, MODE_I2C_SLAVE, MODE_OFF} port_mode_t;
  typedef enum logic [1:0] {SDA_IDLE, SDA_WAIT, SDA_OUT} sda_state_t;
endpackage

// File: verilog/sda_hold_if.sv
// Interface between the control logic and the SDA hold timer
`timescale 1ns/1ns
interface sda_hold_if;
  logic       longHold;
  logic       sclFall;
  logic       sdaWant;
  logic       sdaLow;
  modport ctrl  (output longHold, output sclFall, output sdaWant, input sdaLow);
  modport timer (input longHold, input sclFall, input sdaWant, output sdaLow);
endinterface

// File: verilog/sda_hold_timer.sv
// Delays SDA changes after an SCL falling edge by the selected hold time
`timescale 1ns/1ns
`include "serial_port_params.svh"
module sda_hold_timer
  import serial_port_pkg::*;
(
  input wire logic     core_clk,
  input wire logic     reset,
  sda_hold_if.timer    hold
);
  import serial_port_pkg::*;
  localparam logic [3:0] LongCyc  = 4'(`HOLD_LONG_CYC);
  localparam logic [3:0] ShortCyc = 4'(`HOLD_SHORT_CYC);
  sda_state_t state_reg, state_next;
  logic [3:0] count_reg, count_next;
  logic       sdaLow_reg, sdaLow_next;
  // ============================================================
  // Hold sequencing
  always_comb
  begin
    state_next  = state_reg;
    count_next  = count_reg;
    sdaLow_next = sdaLow_reg;
    unique case (state_reg)
      SDA_IDLE:
        if (hold.sclFall)
        begin
          // Count starts at the edge; SDA stays put until it runs out [R5]
          count_next = hold.longHold ? LongCyc : ShortCyc;
          state_next = SDA_WAIT;
        end
      SDA_WAIT:
        if (count_reg <= 4'h1)
          state_next = SDA_OUT;
        else
          count_next = count_reg - 4'h1;
      SDA_OUT:
      begin
        sdaLow_next = hold.sdaWant; // [R5]
        state_next  = SDA_IDLE;
      end
      default:
        state_next = SDA_IDLE;
    endcase
  end
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      state_reg  <= SDA_IDLE;
      count_reg  <= 4'h0;
      sdaLow_reg <= 1'b0;
    end
    else
    begin
      state_reg  <= state_next;
      count_reg  <= count_next;
      sdaLow_reg <= sdaLow_next;
    end
  end
  assign hold.sdaLow = sdaLow_reg;
endmodule // sda_hold_timer

// File: verilog/serial_port_buffer_overwrite_ctrl.sv
// Receive buffer overwrite policy and SDA hold select with APB registers
`timescale 1ns/1ns
`include "serial_port_params.svh"
// Behaviour
// (R1) SPI slave: overwrite loads always, else overflow
// (R2) I2C master ignores overwrite enable
// (R3) I2C slave overwrite: load, acknowledge if not full
// (R4) I2C slave no overwrite: load only without overflow
// (R5) SDA held 300 or 100 ns
// (R6) Full set on load, cleared on read
module serial_port_buffer_overwrite_ctrl
  import serial_port_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        reset,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        rxValid,
  input  wire logic        rxIsData,
  input  wire logic [7:0]  rxByte,
  input  wire logic        sclFall,
  output logic             sdaIn,
  output logic             sdaOut,
  output logic             sdaOe,
  input  wire logic        sdaPin,
  output logic             irq
);
  import serial_port_pkg::*;
  logic [7:0] control_reg, control_next;
  logic [7:0] buffer_reg, buffer_next;
  logic       full_reg, full_next;
  logic       ovf_reg, ovf_next;
  logic       ack_reg, ack_next;
  logic [1:0] mode_reg, mode_next;
  logic [1:0] irqStat_reg, irqStat_next;
  logic [1:0] irqMask_reg, irqMask_next;
  logic [31:0] rdata_reg, rdata_next;
  logic       load;
  logic       overflowEvt;
  logic       busWrite;
  logic       busRead;
  port_mode_t mode;
  sda_hold_if hold ();

  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = (a == off);
  endfunction

  // ============================================================
  // Receive policy
  assign mode = port_mode_t'(mode_reg);
  always_comb
  begin
    load        = 1'b0;
    overflowEvt = 1'b0;
    if (rxValid)
    begin
      unique case (mode)
        MODE_SPI_SLAVE:
          if (control_reg[`BIT_OVERWRITE] || !full_reg)
            load = 1'b1; // [R1]
          else
            overflowEvt = 1'b1; // [R1]
        MODE_I2C_MASTER:
          begin
            // Overwrite bit not consulted here [R2]
            load        = !full_reg;
            overflowEvt = full_reg;
          end
        MODE_I2C_SLAVE:
          if (control_reg[`BIT_OVERWRITE])
          begin
            load        = !full_reg; // [R3]
            overflowEvt = full_reg;
          end
          else
          begin
            load        = !ovf_reg && !full_reg; // [R4]
            overflowEvt = ovf_reg || full_reg;
          end
        MODE_OFF:
          load = 1'b0;
      endcase
    end
  end

  // ============================================================
  // APB slave, zero wait states
  assign busWrite = psel && penable && pwrite;
  assign busRead  = psel && !penable && !pwrite;
  assign pready   = 1'b1;
  assign pslverr  = 1'b0;
  assign prdata   = rdata_reg;

  always_comb
  begin
    control_next = control_reg;
    buffer_next  = buffer_reg;
    full_next    = full_reg;
    ovf_next     = ovf_reg;
    ack_next     = 1'b0;
    mode_next    = mode_reg;
    irqStat_next = irqStat_reg;
    irqMask_next = irqMask_reg;
    rdata_next   = rdata_reg;
    // Read data fetched in setup so it is stable at the access edge
    if (busRead)
    begin
      rdata_next = 32'h0;
      if (hit(paddr, `OFF_CONTROL_THREE))
        rdata_next = {24'h0, control_reg};
      else if (hit(paddr, `OFF_RX_BUFFER))
        rdata_next = {24'h0, buffer_reg};
      else if (hit(paddr, `OFF_STATUS))
        rdata_next = {30'h0, ovf_reg, full_reg};
      else if (hit(paddr, `OFF_MODE))
        rdata_next = {30'h0, mode_reg};
      else if (hit(paddr, `OFF_IRQ_STATUS))
        rdata_next = {30'h0, irqStat_reg};
      else if (hit(paddr, `OFF_IRQ_MASK))
        rdata_next = {30'h0, irqMask_reg};
    end
    if (psel && penable && !pwrite && hit(paddr, `OFF_RX_BUFFER))
      full_next = 1'b0; // [R6]
    if (busWrite)
    begin
      if (hit(paddr, `OFF_CONTROL_THREE))
        control_next = pwdata[7:0];
      if (hit(paddr, `OFF_STATUS) && pwdata[`BIT_OVERFLOW])
        ovf_next = 1'b0;
      if (hit(paddr, `OFF_MODE))
        mode_next = pwdata[1:0];
      if (hit(paddr, `OFF_IRQ_STATUS))
        irqStat_next = irqStat_reg & ~pwdata[1:0];
      if (hit(paddr, `OFF_IRQ_MASK))
        irqMask_next = pwdata[1:0];
    end
    // Hardware events win over clears in the same cycle
    if (load)
    begin
      buffer_next = rxByte;
      full_next   = 1'b1; // [R6]
      irqStat_next[`IRQ_RX] = 1'b1;
      ack_next    = (mode == MODE_I2C_SLAVE); // [R3]
    end
    if (overflowEvt)
    begin
      ovf_next = 1'b1; // [R1]
      irqStat_next[`IRQ_OVF] = 1'b1;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      control_reg <= `CONTROL_THREE_RST;
      buffer_reg  <= 8'h00;
      full_reg    <= 1'b0;
      ovf_reg     <= 1'b0;
      ack_reg     <= 1'b0;
      mode_reg    <= 2'h0;
      irqStat_reg <= 2'h0;
      irqMask_reg <= 2'h0;
      rdata_reg   <= 32'h0;
    end
    else
    begin
      control_reg <= control_next;
      buffer_reg  <= buffer_next;
      full_reg    <= full_next;
      ovf_reg     <= ovf_next;
      ack_reg     <= ack_next;
      mode_reg    <= mode_next;
      irqStat_reg <= irqStat_next;
      irqMask_reg <= irqMask_next;
      rdata_reg   <= rdata_next;
    end
  end

  assign irq = |(irqStat_reg & irqMask_reg);

  // ============================================================
  // SDA drive, acknowledge pulls low after the hold time
  logic ackPending_reg, ackPending_next;
  always_comb
  begin
    ackPending_next = ackPending_reg;
    if (ack_reg)
      ackPending_next = 1'b1;
    else if (sclFall && ackPending_reg && !hold.sdaLow)
      ackPending_next = 1'b1;
    else if (hold.sdaLow)
      ackPending_next = 1'b0;
  end
  always_ff @(posedge core_clk)
  begin
    if (reset)
      ackPending_reg <= 1'b0;
    else
      ackPending_reg <= ackPending_next;
  end
  assign hold.longHold = control_reg[`BIT_HOLD_SELECT]; // [R5]
  assign hold.sclFall  = sclFall && (mode != MODE_SPI_SLAVE);
  assign hold.sdaWant  = ackPending_reg;

  sda_hold_timer holdTimer (
    .core_clk (core_clk),
    .reset    (reset),
    .hold     (hold)
  );

  assign sdaOut = 1'b0;
  assign sdaOe  = hold.sdaLow;
  assign sdaIn  = sdaPin;
endmodule // serial_port_buffer_overwrite_ctrl

// File: verification/serial_port_chk.sv
// Port checker for the overwrite control block
`timescale 1ns/1ns
`include "serial_port_params.svh"
module serial_port_chk (
  input wire logic        core_clk,
  input wire logic        reset,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        rxValid,
  input wire logic        sclFall,
  input wire logic        sdaOut,
  input wire logic        sdaOe,
  input wire logic        irq
);
  logic       longH;
  logic [3:0] since;
  wire        wrAcc = psel && penable && pwrite;
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  // ====
  // Snooped hold select, saturating count since SCL fell
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      longH <= 1'b0;
      since <= 4'hf;
    end
    else
    begin
      if (wrAcc && paddr == `OFF_CONTROL_THREE) longH <= pwdata[3];
      since <= sclFall ? 4'h0 : (since == 4'hf ? since : since + 4'h1);
    end
  end
  // ====
  // Assertions
  AST_HOLD_LONG: assert property (sclFall && longH |=> $stable(sdaOe)[*6])
    else $error("sda moved in long hold");
  AST_HOLD_SHORT: assert property (sclFall && !longH |=> $stable(sdaOe)[*2])
    else $error("sda moved in short hold");
  AST_HOLD_COUNT: assert property ($changed(sdaOe) |-> since >= (longH ? 4'h6 : 4'h2))
    else $error("sda moved too soon");
  AST_OPEN_DRAIN: assert property (sdaOut == 1'b0)
    else $error("sda driven high");
  AST_IRQ_RISE: assert property ($rose(irq) |-> $past(rxValid) || $past(wrAcc))
    else $error("irq rose without cause");
  AST_IRQ_FALL: assert property ($fell(irq) |-> $past(wrAcc))
    else $error("irq fell without write");
  cover property ($rose(sdaOe) && longH);
  cover property ($rose(sdaOe) && !longH);
  cover property ($rose(irq));
endmodule // serial_port_chk

// File: verification/bus_master_model.sv
// Far-side bus master: offers received bytes and SCL falls
`timescale 1ns/1ns
module bus_master_model (
  input wire logic  core_clk,
  output logic       rxValid = 1'b0,
  output logic       rxIsData = 1'b0,
  output logic [7:0] rxByte = 8'h00,
  output logic       sclFall = 1'b0
);
  task automatic sendByte(input logic [7:0] b);
    @(posedge core_clk);
    rxValid  <= 1'b1;
    rxIsData <= 1'b1;
    rxByte   <= b;
    @(posedge core_clk);
    rxValid  <= 1'b0;
    rxByte   <= ~b; // No stale byte once released
  endtask
  task automatic sclEdge();
    @(posedge core_clk);
    sclFall <= 1'b1;
    @(posedge core_clk);
    sclFall <= 1'b0;
  endtask
endmodule // bus_master_model

// File: verification/tb.sv
// Top bench: APB register tests with far-side traffic
`timescale 1ns/1ns
`include "serial_port_params.svh"
module tb;
  import serial_port_pkg::*;
  logic        core_clk = 1'b0;
  logic        reset = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, q;
  logic [7:0]  rxByte;
  logic        pready, pslverr, irq, sdaIn, sdaOut, sdaOe, rxValid, rxIsData, sclFall;
  int          errCount = 0, cmpCount = 0, cyc = 0;
  wire         sdaPin = sdaOe ? sdaOut : 1'b1; // Pull-up when released
  serial_port_buffer_overwrite_ctrl i_serial_port_buffer_overwrite_ctrl (.core_clk, .reset, .psel,
    .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .rxValid, .rxIsData, .rxByte,
    .sclFall, .sdaIn, .sdaOut, .sdaOe, .sdaPin, .irq);
  bus_master_model i_bus_master_model (.core_clk, .rxValid, .rxIsData, .rxByte, .sclFall);
  initial forever #25 core_clk = ~core_clk;
  // ====
  // Tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmpCount++;
    if (seen !== exp)
    begin
      errCount++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    q = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    acc(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  task automatic hold(input int n, input logic lvl);
    int k;
    i_bus_master_model.sclEdge();
    k = 0;
    while (sdaOe !== lvl && k < 20)
    begin
      @(negedge core_clk);
      k++;
    end
    chk(32'(k > n && k < 20), 32'h1);
    chk({31'h0, sdaIn}, {31'h0, ~lvl});
  endtask
  task automatic scen(input logic [31:0] m, c, input logic [7:0] b1, b2, eb, input logic [31:0] es);
    acc(1'b1, `OFF_MODE, m);
    acc(1'b1, `OFF_CONTROL_THREE, c);
    i_bus_master_model.sendByte(b1);
    i_bus_master_model.sendByte(b2);
    rd(`OFF_STATUS, es);
    rd(`OFF_RX_BUFFER, {24'h0, eb});
    rd(`OFF_STATUS, es & 32'h2);
    $display("test mode %0d ctrl %h done", m, c);
  endtask
  task automatic endOfTest();
    $display("compares %0d mismatches %0d", cmpCount, errCount);
    if (errCount == 0 && cmpCount > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // ====
  // Timeout: the tests need well under a thousand cycles
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      errCount++;
      endOfTest();
    end
  end
  // ====
  // Main sequence
  initial
  begin
    repeat (20) @(posedge core_clk);
    reset <= 1'b0;
    rd(`OFF_CONTROL_THREE, 32'h0);
    rd(`OFF_IRQ_MASK, 32'h0);
    acc(1'b1, 12'h018, 32'hff);
    rd(12'h018, 32'h0);
    chk({30'h0, pready, pslverr}, 32'h2);
    acc(1'b1, `OFF_IRQ_MASK, 32'h3);
    scen(0, 32'h10, 8'ha1, 8'ha2, 8'ha2, 32'h1);
    scen(0, 32'h00, 8'hb1, 8'hb2, 8'hb1, 32'h3);
    chk({31'h0, irq}, 32'h1);
    acc(1'b1, `OFF_IRQ_MASK, 32'h0);
    // Let the access edge settle before looking at the level output
    @(negedge core_clk);
    chk({31'h0, irq}, 32'h0);
    acc(1'b1, `OFF_IRQ_MASK, 32'h3);
    acc(1'b1, `OFF_IRQ_STATUS, 32'h3);
    @(negedge core_clk);
    chk({31'h0, irq}, 32'h0);
    acc(1'b1, `OFF_STATUS, 32'h2);
    scen(1, 32'h10, 8'hc1, 8'hc2, 8'hc1, 32'h3);
    scen(1, 32'h00, 8'hc3, 8'hc4, 8'hc3, 32'h3);
    scen(2, 32'h10, 8'hd1, 8'hd2, 8'hd1, 32'h3);
    hold(2, 1'b1);
    hold(2, 1'b0);
    scen(2, 32'h08, 8'he1, 8'he2, 8'hd1, 32'h2);
    acc(1'b1, `OFF_STATUS, 32'h2);
    i_bus_master_model.sendByte(8'h71);
    rd(`OFF_RX_BUFFER, 32'h71);
    hold(6, 1'b1);
    hold(6, 1'b0);
    $display("test hold done");
    // Port switched off: offered bytes are dropped without flags
    acc(1'b1, `OFF_MODE, 32'h3);
    i_bus_master_model.sendByte(8'h55);
    rd(`OFF_STATUS, 32'h0);
    rd(`OFF_RX_BUFFER, 32'h71);
    $display("test mode off done");
    endOfTest();
  end
endmodule // tb
bind serial_port_buffer_overwrite_ctrl serial_port_chk i_serial_port_chk (.core_clk, .reset, .psel,
  .penable, .pwrite, .paddr, .pwdata, .rxValid, .sclFall, .sdaOut, .sdaOe, .irq);
